// file: src/slb_pkg.sv
// constants and types shared by the serial latch bus master
package slb_pkg;

  // register byte offsets on the wishbone bus
  localparam logic [5:0] SLB_TX0_OFS  = 6'h00;
  localparam logic [5:0] SLB_TX1_OFS  = 6'h04;
  localparam logic [5:0] SLB_TX2_OFS  = 6'h08;
  localparam logic [5:0] SLB_CTRL_OFS = 6'h0c;
  localparam logic [5:0] SLB_RX0_OFS  = 6'h10;
  localparam logic [5:0] SLB_RX1_OFS  = 6'h14;
  localparam logic [5:0] SLB_RX2_OFS  = 6'h18;
  localparam logic [5:0] SLB_STRW_OFS = 6'h1c;
  localparam logic [5:0] SLB_MISC_OFS = 6'h20;

  // transfer_control_word fields
  localparam int SLB_CTRL_GO  = 7;
  localparam int SLB_CTRL_BUS = 6;
  localparam int SLB_CTRL_ANS = 5;
  localparam int SLB_CTRL_L3  = 3;
  localparam int SLB_CTRL_L2  = 2;
  localparam int SLB_CTRL_L1  = 1;
  localparam int SLB_CTRL_L0  = 0;

  // misc register fields
  localparam int SLB_MISC_HOLD = 0;
  localparam int SLB_MISC_BUSY = 1;
  localparam int SLB_MISC_L3ON = 2;

  // values after reset
  localparam logic [7:0]  SLB_CTRL_RST = 8'h00;
  localparam logic [6:0]  SLB_STRW_RST = 7'h00;
  localparam logic [31:0] SLB_RD_NONE  = 32'h0000_0000;

  // counts of serial bus clock falling edges
  localparam logic [4:0] SLB_FRAME_BITS = 5'h18;
  localparam logic [4:0] SLB_ANS_EDGE   = 5'h05;
  localparam logic [6:0] SLB_STR_UNIT   = 7'h64;

  typedef enum logic [2:0] {
    SLB_IDLE,
    SLB_SHIFT,
    SLB_LATCH,
    SLB_WAIT_ANS,
    SLB_RECV
  } slb_state_e;

  // classic wishbone request from the master
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [5:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } slb_wb_req_s;

endpackage

// file: src/slb_edge_sync.sv
// three-stage synchroniser with settled level and edge pulses
module slb_edge_sync #(
  parameter int W = 2
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] sig_i,
  output logic      [W-1:0] lvl_o,
  output logic      [W-1:0] rise_o,
  output logic      [W-1:0] fall_o
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] lvl;
    logic [W-1:0] rise;
    logic [W-1:0] fall;
  } slb_sync_s;

  slb_sync_s s_q;
  slb_sync_s s_d;

  // a change counts only once stages two and three agree
  always_comb
  begin
    s_d    = s_q;
    s_d.s1 = sig_i;
    s_d.s2 = s_q.s1;
    s_d.s3 = s_q.s2;
    for (int i = 0; i < W; i++)
    begin
      s_d.rise[i] = 1'b0;
      s_d.fall[i] = 1'b0;
      if ((s_q.s2[i] == s_q.s3[i]) && (s_q.s3[i] != s_q.lvl[i]))
      begin
        s_d.lvl[i]  = s_q.s3[i];
        s_d.rise[i] = s_q.s3[i];
        s_d.fall[i] = ~s_q.s3[i];
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign lvl_o  = s_q.lvl;
  assign rise_o = s_q.rise;
  assign fall_o = s_q.fall;

endmodule

// file: src/slb_master.sv
// serial latch bus master: 24-bit shift out, latches, answer capture
// Contract
// [R1] setting go starts the shift clocking and the transfer
// [R2] 24 transmit bits leave on the data line, one per falling bus edge
// [R3] next falling edge after last bit pulses the latch and send-done together
// [R4] control word is cleared once the latch is generated
// [R5] software loads a non-zero strobe width before a latch 3 bus transfer
// [R6] answer capture starts on the fifth falling edge after the latch
// [R7] after 24 captured bits, read registers load and receive-done pulses
// [R8] answer transfers still pulse send-done with the latch
// [R9] answer bytes: preamble first, then two result bytes
// [R10] software leaves tx and control alone 25us or until send-done
// [R11] with answer, software waits 6 bus clocks after send-done
// [R12] with answer, no new go until 55us or receive-done
// [R13] strobe width stays zero for latches 0, 1, 2 and link latch 3
// [R14] software never uses control bus and synth link at once
// [R15] control bus words: go and bus select high, latch bits 0 or 1
// [R16] synth link words: go, bus select low, bit 3 or bit 2
// [R17] latch 3 strobe lasts the programmed time; writing zero ends it
// [R18] other transfers may run while the latch 3 strobe is high
// [R19] hold-high bit keeps latch 3 asserted if set before expiry
// [R20] strobe time counting starts when the serial transfer completes
// [R21] first transmit byte msb goes first, then second and third bytes
// [R22] 7-bit strobe width counts units of 100 bus clocks, decrementing
// [R23] data line is released after each transfer for the answer
module slb_master (
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  input  wire slb_pkg::slb_wb_req_s wb_req_i,
  output logic                      wb_ack_o,
  output logic [31:0]               wb_dat_o,
  input  wire logic                 serial_bus_clock_i,
  input  wire logic                 serial_data_line_i,
  output logic                      serial_data_line_o,
  output logic                      serial_data_line_oe_n_o,
  output logic [3:0]                latch_o,
  output logic                      send_done_o,
  output logic                      receive_done_irq_o
);

  typedef struct packed {
    slb_pkg::slb_state_e st;
    logic [4:0]          cnt;
    logic [23:0]         txsh;
    logic [23:0]         rxsh;
    logic [7:0]          ctrl;
    logic [2:0][7:0]     tx;
    logic [2:0][7:0]     rx;
    logic [6:0]          strw;
    logic [6:0]          pre;
    logic                l3_on;
    logic                hold;
    logic [3:0]          pulse;
    logic                dout;
    logic                oe_n;
    logic                send_done;
    logic                recv_done;
    logic                ack;
    logic [31:0]         rdat;
  } slb_core_s;

  slb_core_s s_q;
  slb_core_s s_d;

  logic [1:0] sync_lvl;
  logic [1:0] sync_rise;
  logic [1:0] sync_fall;
  logic       bus_fall;
  logic       bus_rise;
  logic       din;
  logic       wb_req;
  logic       wb_wr;

  // bit 0 is the bus clock, bit 1 the data line
  slb_edge_sync #(
    .W(2)
  ) u_sync (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .sig_i  ({serial_data_line_i, serial_bus_clock_i}),
    .lvl_o  (sync_lvl),
    .rise_o (sync_rise),
    .fall_o (sync_fall)
  );

  assign bus_fall = sync_fall[0];
  assign bus_rise = sync_rise[0];
  assign din      = sync_lvl[1];

  // write lands on the edge where the master samples ack
  assign wb_req = wb_req_i.cyc && wb_req_i.stb;
  assign wb_wr  = wb_req && wb_req_i.we && s_q.ack && wb_req_i.sel[0];

  // read data mux, unmapped words read as zero
  function automatic logic [31:0] rd_mux(input slb_core_s s, input logic [5:0] adr);
    logic [31:0] r;
    r = slb_pkg::SLB_RD_NONE;
    case (adr)
      slb_pkg::SLB_TX0_OFS:  r[7:0] = s.tx[0];
      slb_pkg::SLB_TX1_OFS:  r[7:0] = s.tx[1];
      slb_pkg::SLB_TX2_OFS:  r[7:0] = s.tx[2];
      slb_pkg::SLB_CTRL_OFS: r[7:0] = s.ctrl;
      slb_pkg::SLB_RX0_OFS:  r[7:0] = s.rx[0]; // R9
      slb_pkg::SLB_RX1_OFS:  r[7:0] = s.rx[1];
      slb_pkg::SLB_RX2_OFS:  r[7:0] = s.rx[2];
      slb_pkg::SLB_STRW_OFS: r[6:0] = s.strw;
      slb_pkg::SLB_MISC_OFS:
      begin
        r[slb_pkg::SLB_MISC_HOLD] = s.hold;
        r[slb_pkg::SLB_MISC_BUSY] = (s.st != slb_pkg::SLB_IDLE);
        r[slb_pkg::SLB_MISC_L3ON] = s.l3_on;
      end
      default: r = slb_pkg::SLB_RD_NONE;
    endcase
    return r;
  endfunction

  // next state of the whole block
  always_comb
  begin
    s_d           = s_q;
    s_d.ack       = 1'b0;
    s_d.send_done = 1'b0;
    s_d.recv_done = 1'b0;

    // single wait state answer; ack drops the cycle after it was given
    if (wb_req && !s_q.ack)
    begin
      s_d.ack  = 1'b1;
      s_d.rdat = rd_mux(s_q, wb_req_i.adr);
    end

    // register writes, only the low byte lane carries data
    if (wb_wr)
    begin
      case (wb_req_i.adr)
        slb_pkg::SLB_TX0_OFS:  s_d.tx[0] = wb_req_i.dat[7:0];
        slb_pkg::SLB_TX1_OFS:  s_d.tx[1] = wb_req_i.dat[7:0];
        slb_pkg::SLB_TX2_OFS:  s_d.tx[2] = wb_req_i.dat[7:0];
        slb_pkg::SLB_CTRL_OFS: s_d.ctrl  = wb_req_i.dat[7:0];
        slb_pkg::SLB_STRW_OFS: s_d.strw  = wb_req_i.dat[6:0]; // R17
        slb_pkg::SLB_MISC_OFS: s_d.hold  = wb_req_i.dat[slb_pkg::SLB_MISC_HOLD];
        default: s_d.ctrl = s_d.ctrl;
      endcase
    end

    // fixed latch pulses end on the next rising edge, about half a period
    if (bus_rise)
      s_d.pulse = 4'h0;

    // transfer sequencer, stepped by falling edges of the bus clock
    case (s_q.st)
      slb_pkg::SLB_IDLE:
      begin
        if (s_q.ctrl[slb_pkg::SLB_CTRL_GO])
        begin
          s_d.st   = slb_pkg::SLB_SHIFT; // R1
          s_d.cnt  = 5'h00;
          s_d.txsh = {s_q.tx[0], s_q.tx[1], s_q.tx[2]}; // R21
        end
      end
      slb_pkg::SLB_SHIFT:
      begin
        if (bus_fall)
        begin
          if (s_q.cnt == slb_pkg::SLB_FRAME_BITS)
          begin
            // latch and send-done share this edge
            s_d.st        = slb_pkg::SLB_LATCH;
            s_d.send_done = 1'b1; // R3 R8
            s_d.oe_n      = 1'b1; // R23
            s_d.ctrl      = slb_pkg::SLB_CTRL_RST; // R4
            if (s_q.ctrl[slb_pkg::SLB_CTRL_BUS])
            begin
              s_d.pulse[0] = s_q.ctrl[slb_pkg::SLB_CTRL_L0];
              s_d.pulse[1] = s_q.ctrl[slb_pkg::SLB_CTRL_L1];
              if (s_q.ctrl[3:0] == 4'h0)
              begin
                if (s_q.strw != 7'h00)
                begin
                  s_d.l3_on = 1'b1; // R20
                  s_d.pre   = 7'h00;
                end
                else
                  s_d.pulse[3] = 1'b1;
              end
            end
            else
            begin
              s_d.pulse[2] = s_q.ctrl[slb_pkg::SLB_CTRL_L2];
              s_d.pulse[3] = s_q.ctrl[slb_pkg::SLB_CTRL_L3];
            end
            // answer flag lives on once the control word is cleared
            s_d.cnt = {4'h0, s_q.ctrl[slb_pkg::SLB_CTRL_ANS]};
          end
          else
          begin
            s_d.dout = s_q.txsh[23]; // R2 R21
            s_d.oe_n = 1'b0;
            s_d.txsh = {s_q.txsh[22:0], 1'b0};
            s_d.cnt  = s_q.cnt + 5'h01;
          end
        end
      end
      slb_pkg::SLB_LATCH:
      begin
        // first falling edge after the latch edge
        if (bus_fall)
        begin
          if (s_q.cnt[0])
          begin
            s_d.st  = slb_pkg::SLB_WAIT_ANS;
            s_d.cnt = 5'h01;
          end
          else
            s_d.st = slb_pkg::SLB_IDLE;
        end
      end
      slb_pkg::SLB_WAIT_ANS:
      begin
        // give the slave four edges of response time
        if (bus_fall)
        begin
          if (s_q.cnt == (slb_pkg::SLB_ANS_EDGE - 5'h01))
          begin
            s_d.st   = slb_pkg::SLB_RECV; // R6
            s_d.rxsh = {s_q.rxsh[22:0], din};
            s_d.cnt  = 5'h01;
          end
          else
            s_d.cnt = s_q.cnt + 5'h01;
        end
      end
      slb_pkg::SLB_RECV:
      begin
        if (bus_fall)
        begin
          s_d.rxsh = {s_q.rxsh[22:0], din};
          s_d.cnt  = s_q.cnt + 5'h01;
          if (s_q.cnt == (slb_pkg::SLB_FRAME_BITS - 5'h01))
          begin
            s_d.rx[0]     = s_d.rxsh[23:16]; // R7 R9
            s_d.rx[1]     = s_d.rxsh[15:8];
            s_d.rx[2]     = s_d.rxsh[7:0];
            s_d.recv_done = 1'b1;
            s_d.st        = slb_pkg::SLB_IDLE;
          end
        end
      end
      default: s_d.st = slb_pkg::SLB_IDLE;
    endcase

    // latch 3 strobe runs beside the sequencer so other latches can follow
    if (s_q.l3_on) // R18
    begin
      if (s_d.strw == 7'h00)
        s_d.l3_on = s_q.hold; // R17 R19
      else if (bus_fall)
      begin
        if (s_q.pre == (slb_pkg::SLB_STR_UNIT - 7'h01))
        begin
          s_d.pre  = 7'h00;
          s_d.strw = s_d.strw - 7'h01; // R22
        end
        else
          s_d.pre = s_q.pre + 7'h01;
      end
    end
  end

  // a reset leaves the data line released and every latch low
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s_q      <= '0;
      s_q.oe_n <= 1'b1;
    end
    else
      s_q <= s_d;
  end

  assign wb_ack_o                = s_q.ack;
  assign wb_dat_o                = s_q.rdat;
  assign serial_data_line_o      = s_q.dout;
  assign serial_data_line_oe_n_o = s_q.oe_n;
  assign latch_o                 = s_q.pulse | {s_q.l3_on, 3'h0};
  assign send_done_o             = s_q.send_done;
  assign receive_done_irq_o      = s_q.recv_done;

  // last bit clocked and the next falling edge arrives
  sequence seq_frame_end;
    (s_q.st == slb_pkg::SLB_SHIFT) && bus_fall && (s_q.cnt == slb_pkg::SLB_FRAME_BITS);
  endsequence

  sequence seq_first_bit;
    (s_q.st == slb_pkg::SLB_SHIFT) && bus_fall && (s_q.cnt == 5'h00);
  endsequence

  AST_GO_STARTS: assert property (@(posedge clk_i) disable iff (rst_i) // R1
    (s_q.st == slb_pkg::SLB_IDLE) && s_q.ctrl[slb_pkg::SLB_CTRL_GO]
    |=> (s_q.st == slb_pkg::SLB_SHIFT))
    else $error("go did not start a transfer");

  AST_MSB_FIRST: assert property (@(posedge clk_i) disable iff (rst_i) // R21
    seq_first_bit |=> (serial_data_line_o == $past(s_q.txsh[23]))
      && !serial_data_line_oe_n_o)
    else $error("first bit is not the msb of the first byte");

  AST_LATCH_WITH_SEND: assert property (@(posedge clk_i) disable iff (rst_i) // R3
    seq_frame_end |=> send_done_o && (s_q.st == slb_pkg::SLB_LATCH))
    else $error("send-done not raised at the latch edge");

  AST_CTRL_CLEARED: assert property (@(posedge clk_i) disable iff (rst_i) // R4
    send_done_o |-> (s_q.ctrl == slb_pkg::SLB_CTRL_RST))
    else $error("control word not cleared after latch");

  AST_RELEASE_LINE: assert property (@(posedge clk_i) disable iff (rst_i) // R23
    (s_q.st != slb_pkg::SLB_SHIFT) |-> serial_data_line_oe_n_o)
    else $error("data line driven outside the shift phase");

  AST_ANS_FOLLOWS: assert property (@(posedge clk_i) disable iff (rst_i) // R8
    seq_frame_end ##0 s_q.ctrl[slb_pkg::SLB_CTRL_ANS] |=> send_done_o && s_q.cnt[0])
    else $error("send-done missing on an answer transfer");

  AST_ANS_WAIT: assert property (@(posedge clk_i) disable iff (rst_i) // R6
    (s_q.st == slb_pkg::SLB_LATCH) && bus_fall && s_q.cnt[0]
    |=> (s_q.st == slb_pkg::SLB_WAIT_ANS))
    else $error("answer phase did not follow the latch");

  AST_RECV_DONE: assert property (@(posedge clk_i) disable iff (rst_i) // R7
    receive_done_irq_o |-> ($past(s_q.st) == slb_pkg::SLB_RECV)
      && (s_q.rx[2] == s_q.rxsh[7:0]) && (s_q.rx[0] == s_q.rxsh[23:16]))
    else $error("read registers not loaded with receive-done");

  AST_HOLD_KEEPS: assert property (@(posedge clk_i) disable iff (rst_i) // R19
    s_q.l3_on && s_q.hold && !(wb_wr && (wb_req_i.adr == slb_pkg::SLB_MISC_OFS))
    |=> s_q.l3_on)
    else $error("latch 3 dropped while hold-high set");

  AST_STROBE_ZERO_ENDS: assert property (@(posedge clk_i) disable iff (rst_i) // R17
    s_q.l3_on && (s_q.strw == 7'h00) && !s_q.hold |=> !s_q.l3_on)
    else $error("zero strobe width did not end latch 3");

endmodule

// file: tb/slb_slave_model.sv
// far-side slave model: bus clock, word capture and answer drive
module slb_slave_model (
  input  wire logic        clk_i,
  input  wire logic [3:0]  latch_i,
  input  wire logic        dat_i,
  input  wire logic        oe_n_i,
  input  wire logic        ans_en_i,
  input  wire logic [23:0] ans_i,
  output logic             sclk_o,
  output logic             line_o,
  output logic [23:0]      word_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [23:0] sh;
  logic [3:0]  lq;
  logic        drv = 1'b0;
  logic        bit_v = 1'b0;
  logic        idle_v = 1'b0;
  logic        act = 1'b0;
  int          k = 0;
  // free running clock, offset so no edge meets the system clock
  initial
  begin
    sclk_o = 1'b1;
    #3.1;
    forever #62.5 sclk_o = ~sclk_o;
  end
  // a released line toggles unless the slave drives its answer, it never keeps the last bit
  assign line_o = !oe_n_i ? dat_i : (drv ? bit_v : idle_v);
  // master bits taken mid-bit; answer set up ahead of falls 5..28
  always @(posedge sclk_o)
  begin
    idle_v <= ~idle_v;
    if (!oe_n_i)
      sh <= {sh[22:0], dat_i};
    if (!act && latch_i[1] && ans_en_i)
    begin
      act = 1'b1;
      k = 0;
    end
    drv = act && k >= 4 && k <= 27;
    if (drv)
      bit_v = ans_i[27-k];
    if (k > 27)
      act = 1'b0;
  end
  always @(negedge sclk_o)
    if (act)
      k++;
  // word kept when any latch line rises
  always @(posedge clk_i)
  begin
    lq <= latch_i;
    if ((latch_i & ~lq) != 4'h0)
      word_o <= sh;
  end
endmodule

// file: tb/serial_latch_bus_master_bench.sv
// self-checking bench for the serial latch bus master
module serial_latch_bus_master_bench;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [7:0] CTL_TAB [4] = '{8'hc1, 8'hc2, 8'h84, 8'h88};
  localparam logic [3:0] LAT_TAB [4] = '{4'h1, 4'h2, 4'h4, 4'h8};
  logic                 clk_i = 1'b0;
  logic                 rst_i = 1'b1;
  slb_pkg::slb_wb_req_s wb = '0;
  logic                 ack, sdone, rdone, oe_n, dout, sclk, line;
  logic                 ans_en = 1'b0;
  logic [31:0]          rdat;
  logic [3:0]           latch;
  logic [23:0]          answer_request_bit = 24'h0;
  logic [23:0]          word;
  int                   failures = 0;
  int                   comparisons = 0;
  int                   cyc_cnt = 0;
  int                   t_sd = 0;

  always #5 clk_i = ~clk_i;
  // cycle clock and the cycle of the last send-done
  always @(posedge clk_i)
  begin
    cyc_cnt <= cyc_cnt + 1;
    if (sdone === 1'b1)
      t_sd <= cyc_cnt;
  end

  slb_master DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(wb), .wb_ack_o(ack),
    .wb_dat_o(rdat), .serial_bus_clock_i(sclk), .serial_data_line_i(line),
    .serial_data_line_o(dout), .serial_data_line_oe_n_o(oe_n), .latch_o(latch),
    .send_done_o(sdone), .receive_done_irq_o(rdone));
  slb_slave_model slave (.clk_i(clk_i), .latch_i(latch), .dat_i(dout), .oe_n_i(oe_n),
    .ans_en_i(ans_en), .ans_i(answer_request_bit), .sclk_o(sclk), .line_o(line), .word_o(word));

  // strobe length in system cycles: units of 100 bus clocks of 125 ns
  function automatic int strobe_cycles(input int w);
    return w * int'(slb_pkg::SLB_STR_UNIT) * 25 / 2;
  endfunction

  task automatic finish_test();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp)
    begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // one classic cycle, held until ack is sampled
  task automatic wb_io(input logic we, input logic [5:0] a, input logic [7:0] d,
                       output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    wb <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: 4'hf, dat: {24'h0, d}};
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (ack !== 1'b1 && n < 20);
    q = rdat;
    wb <= '0;
    chk("wb_ack", 32'h1, {31'h0, ack});
  endtask

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    logic [31:0] q;
    wb_io(1'b1, a, d, q);
  endtask

  task automatic rd_chk(input string nm, input logic [5:0] a, input logic [31:0] exp);
    logic [31:0] q;
    wb_io(1'b0, a, 8'h00, q);
    chk(nm, exp, q);
  endtask

  task automatic wait_on(input logic rx);
    int n;
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while ((rx ? rdone : sdone) !== 1'b1 && n < 4000);
    chk("done_pulse", 32'h1, {31'h0, n < 4000});
  endtask

  // whole transfer; software waits as the link demands
  task automatic xfer(input logic [7:0] ctl, input logic [3:0] el, input logic [23:0] w);
    logic [31:0] q;
    int n;
    answer_request_bit <= 24'($urandom);
    ans_en <= ctl[5];
    wr(slb_pkg::SLB_TX0_OFS, w[23:16]);
    wr(slb_pkg::SLB_TX1_OFS, w[15:8]);
    wr(slb_pkg::SLB_TX2_OFS, w[7:0]);
    wr(slb_pkg::SLB_CTRL_OFS, ctl);
    wait_on(1'b0);
    chk("latch", {28'h0, el}, {28'h0, latch});
    chk("oe_n", 32'h1, {31'h0, oe_n});
    repeat (2) @(posedge clk_i);
    chk("word", {8'h0, w}, {8'h0, word});
    if (ctl[5])
    begin
      wait_on(1'b1);
      rd_chk("ans0", slb_pkg::SLB_RX0_OFS, {24'h0, answer_request_bit[23:16]});
      rd_chk("ans1", slb_pkg::SLB_RX1_OFS, {24'h0, answer_request_bit[15:8]});
      rd_chk("ans2", slb_pkg::SLB_RX2_OFS, {24'h0, answer_request_bit[7:0]});
    end
    n = 0;
    do
    begin
      wb_io(1'b0, slb_pkg::SLB_MISC_OFS, 8'h00, q);
      n++;
    end
    while (q[1] !== 1'b0 && n < 100);
    chk("busy_clear", 32'h0, {31'h0, q[1]});
    rd_chk("ctrl_clear", slb_pkg::SLB_CTRL_OFS, 32'h0);
  endtask

  initial
  begin
    int t0;
    int dt;
    t0 = $urandom(32'h4dbb);
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    // reset values, read-only and unmapped places
    rd_chk("ctrl_rst", slb_pkg::SLB_CTRL_OFS, 32'h0);
    rd_chk("strw_rst", slb_pkg::SLB_STRW_OFS, 32'h0);
    rd_chk("misc_rst", slb_pkg::SLB_MISC_OFS, 32'h0);
    wr(slb_pkg::SLB_RX0_OFS, 8'h5a);
    rd_chk("rx0_ro", slb_pkg::SLB_RX0_OFS, 32'h0);
    wr(6'h24, 8'hff);
    rd_chk("unmapped", 6'h24, 32'h0);
    wr(slb_pkg::SLB_STRW_OFS, 8'hff);
    rd_chk("strw_width", slb_pkg::SLB_STRW_OFS, 32'h7f);
    wr(slb_pkg::SLB_STRW_OFS, 8'h00);
    $display("test registers done");
    // every latch select, one edge pattern then random words
    xfer(8'hc1, 4'h1, 24'h800001);
    for (int i = 0; i < 4; i++)
      xfer(CTL_TAB[i], LAT_TAB[i], 24'($urandom));
    $display("test latches done");
    repeat (2) xfer(8'he2, 4'h2, 24'($urandom));
    $display("test answer done");
    // strobe with a transfer inside it
    wr(slb_pkg::SLB_STRW_OFS, 8'h02);
    xfer(8'hc0, 4'h8, 24'($urandom));
    t0 = t_sd;
    xfer(8'hc1, 4'h9, 24'($urandom));
    while (latch[3] === 1'b1 && cyc_cnt - t0 < 6000)
      @(posedge clk_i);
    dt = cyc_cnt - t0 - strobe_cycles(2);
    chk("strobe_len", 32'h1, {31'h0, (dt >= -30) && (dt <= 30)});
    // early end by writing zero
    wr(slb_pkg::SLB_STRW_OFS, 8'h05);
    xfer(8'hc0, 4'h8, 24'($urandom));
    wr(slb_pkg::SLB_STRW_OFS, 8'h00);
    repeat (4) @(posedge clk_i);
    chk("strobe_cut", 32'h0, {31'h0, latch[3]});
    // hold bit set before expiry outlives the count
    wr(slb_pkg::SLB_STRW_OFS, 8'h01);
    xfer(8'hc0, 4'h8, 24'($urandom));
    wr(slb_pkg::SLB_MISC_OFS, 8'h01);
    repeat (strobe_cycles(1) + 300) @(posedge clk_i);
    chk("strobe_hold", 32'h1, {31'h0, latch[3]});
    wr(slb_pkg::SLB_MISC_OFS, 8'h00);
    repeat (4) @(posedge clk_i);
    chk("hold_off", 32'h0, {31'h0, latch[3]});
    $display("test strobe done");
    finish_test();
  end

  // hang guard, well past the expected run length
  initial
  begin
    repeat (60000) @(posedge clk_i);
    failures++;
    finish_test();
  end
endmodule
